// ===== verilog/ata_cmd_engine.sv
module ata_cmd_engine #(
  parameter int unsigned STBY_UNIT_CYCLES = ata_cmd_pkg::STBY_UNIT_CYCLES_DFLT,
  parameter bit SMART_SUPPORTED = 1'b1,
  parameter bit PM_SUPPORTED = 1'b1,
  parameter bit BUF_SUPPORTED = 1'b1,
  parameter bit PRE_SAVE_CAP = 1'b1,
  parameter bit AUTOSAVE_CAP = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic intrq_o,
  output logic nv_save_req_o,
  input wire logic nv_save_ack_i,
  input wire logic thresh_exceeded_i,
  output logic standby_o
);

  ata_cmd_pkg::state_t state_r;
  ata_cmd_pkg::state_t state_nxt;
  ata_cmd_pkg::op_t op_r;
  ata_cmd_pkg::op_t op_nxt;
  logic [7:0] feat_r;
  logic [7:0] seccnt_r;
  logic [7:0] secnum_r;
  logic [7:0] cyllo_r;
  logic [7:0] cylhi_r;
  logic [7:0] devhead_r;
  logic [7:0] err_r;
  logic smart_en_r;
  logic intrq_r;
  logic intrq_nxt;
  logic standby_r;
  logic tmr_en_r;
  logic [7:0] tmr_per_r;
  logic [7:0] tmr_r;
  logic [31:0] div_r;
  logic [31:0] prdata_r;
  logic abort;
  logic stby_set;
  logic tmr_load;
  logic buf_clr;
  logic cyl_upd;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic setup;
  logic sel_data;
  logic sel_errfeat;
  logic sel_seccnt;
  logic sel_secnum;
  logic sel_cyllo;
  logic sel_cylhi;
  logic sel_devhead;
  logic sel_statcmd;
  logic sel_config;
  logic sel_info;
  logic mapped;

  assign acc = psel_i & penable_i;
  assign wr_acc = acc & pwrite_i;
  assign rd_acc = acc & ~pwrite_i;
  assign setup = psel_i & ~penable_i;
  assign sel_data = paddr_i == ata_cmd_pkg::OFF_DATA;
  assign sel_errfeat = paddr_i == ata_cmd_pkg::OFF_ERRFEAT;
  assign sel_seccnt = paddr_i == ata_cmd_pkg::OFF_SECCNT;
  assign sel_secnum = paddr_i == ata_cmd_pkg::OFF_SECNUM;
  assign sel_cyllo = paddr_i == ata_cmd_pkg::OFF_CYLLO;
  assign sel_cylhi = paddr_i == ata_cmd_pkg::OFF_CYLHI;
  assign sel_devhead = paddr_i == ata_cmd_pkg::OFF_DEVHEAD;
  assign sel_statcmd = paddr_i == ata_cmd_pkg::OFF_STATCMD;
  assign sel_config = paddr_i == ata_cmd_pkg::OFF_CONFIG;
  assign sel_info = paddr_i == ata_cmd_pkg::OFF_INFO;
  assign mapped = sel_data | sel_errfeat | sel_seccnt | sel_secnum | sel_cyllo | sel_cylhi |
                  sel_devhead | sel_statcmd | sel_config | sel_info;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic idle;
  logic tf_wr;
  logic cmd_go;
  logic [7:0] cmd;
  logic is_stby;
  logic is_stbyi;
  logic smart_ok;
  logic data_wr;
  logic data_rd;
  logic tick;
  logic counting;
  logic expire;
  logic busy;
  logic drq;
  logic [15:0] cap_word;
  logic [7:0] status;

  function automatic logic code_is(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
    code_is = (c == a) | (c == b);
  endfunction : code_is

  assign idle = state_r == ata_cmd_pkg::ST_IDLE;
  // Task file and command writes are ignored while a command runs
  assign tf_wr = wr_acc & idle;
  assign cmd_go = tf_wr & sel_statcmd;
  assign cmd = pwdata_i[7:0];
  assign is_stby = code_is(cmd, ata_cmd_pkg::CMD_STBY_A, ata_cmd_pkg::CMD_STBY_B);
  assign is_stbyi = code_is(cmd, ata_cmd_pkg::CMD_STBYI_A, ata_cmd_pkg::CMD_STBYI_B);
  assign smart_ok = SMART_SUPPORTED & smart_en_r & (cyllo_r == ata_cmd_pkg::SIG_LO) &
                    (cylhi_r == ata_cmd_pkg::SIG_HI);
  assign data_wr = wr_acc & sel_data & (state_r == ata_cmd_pkg::ST_WR_DATA);
  assign data_rd = rd_acc & sel_data & (state_r == ata_cmd_pkg::ST_RD_DATA);
  assign tick = div_r == (STBY_UNIT_CYCLES - 32'd1);
  assign counting = tmr_en_r & ~standby_r & idle;
  assign expire = counting & tick & (tmr_r == 8'h01) & ~cmd_go;
  assign busy = ~idle & ~drq;
  assign drq = (state_r == ata_cmd_pkg::ST_WR_DATA) | (state_r == ata_cmd_pkg::ST_RD_DATA);
  assign cap_word = {14'h0000, AUTOSAVE_CAP, PRE_SAVE_CAP};
  assign status = {busy, 1'b1, 2'b00, drq, 2'b00, |err_r};

  // ----------------------------------------------------------------
  // Sector buffer
  // ----------------------------------------------------------------
  logic [15:0] buf_rdata;
  logic buf_last;
  logic [7:0] buf_csum;

  sector_buf #(
    .WORDS(ata_cmd_pkg::BUF_WORDS)
  ) u_buf (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .clr_i(buf_clr),
    .wr_i(data_wr),
    .wdata_i(pwdata_i[15:0]),
    .rd_i(data_rd),
    .rdata_o(buf_rdata),
    .last_o(buf_last),
    .csum_o(buf_csum)
  );

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    abort = 1'b0;
    stby_set = 1'b0;
    tmr_load = 1'b0;
    buf_clr = 1'b0;
    cyl_upd = 1'b0;
    case (state_r)
      ata_cmd_pkg::ST_IDLE: begin
        if (cmd_go) begin
          if (cmd == ata_cmd_pkg::CMD_SMART) begin
            if (smart_ok && feat_r == ata_cmd_pkg::FEAT_STATUS) begin
              state_nxt = ata_cmd_pkg::ST_SAVE_WAIT;
              op_nxt = ata_cmd_pkg::OP_STATUS;
            end else if (smart_ok && feat_r == ata_cmd_pkg::FEAT_SAVE) begin
              state_nxt = ata_cmd_pkg::ST_SAVE_WAIT;
              op_nxt = ata_cmd_pkg::OP_SAVE;
            end else begin
              abort = 1'b1;
              state_nxt = ata_cmd_pkg::ST_DONE;
            end
          end else if ((is_stby || is_stbyi) && PM_SUPPORTED) begin
            tmr_load = is_stby;
            if (PRE_SAVE_CAP) begin
              state_nxt = ata_cmd_pkg::ST_SAVE_WAIT;
              op_nxt = ata_cmd_pkg::OP_STANDBY;
            end else begin
              stby_set = 1'b1;
              state_nxt = ata_cmd_pkg::ST_DONE;
            end
          end else if (code_is(cmd, ata_cmd_pkg::CMD_WR_BUF, ata_cmd_pkg::CMD_RD_BUF) && BUF_SUPPORTED) begin
            buf_clr = 1'b1;
            state_nxt = (cmd == ata_cmd_pkg::CMD_WR_BUF) ? ata_cmd_pkg::ST_WR_PREP : ata_cmd_pkg::ST_RD_PREP;
          end else begin
            abort = 1'b1;
            state_nxt = ata_cmd_pkg::ST_DONE;
          end
        end else if (expire) begin
          if (PRE_SAVE_CAP) begin
            state_nxt = ata_cmd_pkg::ST_SAVE_WAIT;
            op_nxt = ata_cmd_pkg::OP_AUTO;
          end else begin
            stby_set = 1'b1;
          end
        end
      end
      ata_cmd_pkg::ST_SAVE_WAIT: begin
        if (nv_save_ack_i) begin
          cyl_upd = op_r == ata_cmd_pkg::OP_STATUS;
          stby_set = (op_r == ata_cmd_pkg::OP_STANDBY) | (op_r == ata_cmd_pkg::OP_AUTO);
          state_nxt = (op_r == ata_cmd_pkg::OP_AUTO) ? ata_cmd_pkg::ST_IDLE : ata_cmd_pkg::ST_DONE;
        end
      end
      ata_cmd_pkg::ST_WR_PREP: begin
        state_nxt = ata_cmd_pkg::ST_WR_DATA;
      end
      ata_cmd_pkg::ST_WR_DATA: begin
        if (data_wr && buf_last) begin
          state_nxt = ata_cmd_pkg::ST_DONE;
        end
      end
      ata_cmd_pkg::ST_RD_PREP: begin
        state_nxt = ata_cmd_pkg::ST_RD_DATA;
      end
      ata_cmd_pkg::ST_RD_DATA: begin
        if (data_rd && buf_last) begin
          state_nxt = ata_cmd_pkg::ST_IDLE;
        end
      end
      ata_cmd_pkg::ST_DONE: begin
        state_nxt = ata_cmd_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = ata_cmd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ata_cmd_pkg::ST_IDLE;
      op_r <= ata_cmd_pkg::OP_STATUS;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt: a new set wins over a status read clear
  // ----------------------------------------------------------------
  assign intrq_nxt = (state_r == ata_cmd_pkg::ST_DONE) | (state_r == ata_cmd_pkg::ST_RD_PREP) |
                     (intrq_r & ~(rd_acc & sel_statcmd) & ~cmd_go);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      intrq_r <= 1'b0;
      err_r <= 8'h00;
    end else begin
      intrq_r <= intrq_nxt;
      if (cmd_go) begin
        err_r <= abort ? ata_cmd_pkg::ERR_ABRT : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Task file registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      feat_r <= 8'h00;
      seccnt_r <= 8'h00;
      secnum_r <= 8'h00;
      devhead_r <= ata_cmd_pkg::DEVHEAD_RST;
      smart_en_r <= ata_cmd_pkg::CONFIG_SMART_RST;
    end else begin
      if (tf_wr && sel_errfeat) feat_r <= pwdata_i[7:0];
      if (tf_wr && sel_seccnt) seccnt_r <= pwdata_i[7:0];
      if (tf_wr && sel_secnum) secnum_r <= pwdata_i[7:0];
      if (tf_wr && sel_devhead) devhead_r <= pwdata_i[7:0];
      if (wr_acc && sel_config) smart_en_r <= pwdata_i[0];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyllo_r <= 8'h00;
      cylhi_r <= 8'h00;
    end else if (cyl_upd) begin
      cyllo_r <= thresh_exceeded_i ? ata_cmd_pkg::BAD_LO : ata_cmd_pkg::SIG_LO;
      cylhi_r <= thresh_exceeded_i ? ata_cmd_pkg::BAD_HI : ata_cmd_pkg::SIG_HI;
    end else begin
      if (tf_wr && sel_cyllo) cyllo_r <= pwdata_i[7:0];
      if (tf_wr && sel_cylhi) cylhi_r <= pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Power state and standby timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      standby_r <= 1'b0;
    end else if (stby_set) begin
      standby_r <= 1'b1;
    end else if (cmd_go && !is_stby && !is_stbyi) begin
      standby_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= 32'd0;
    end else if (tick) begin
      div_r <= 32'd0;
    end else begin
      div_r <= div_r + 32'd1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_en_r <= 1'b0;
      tmr_per_r <= 8'h00;
      tmr_r <= 8'h00;
    end else if (tmr_load) begin
      tmr_en_r <= seccnt_r != 8'h00;
      tmr_per_r <= seccnt_r;
      tmr_r <= seccnt_r;
    end else if (cmd_go || expire) begin
      tmr_r <= tmr_per_r;
    end else if (counting && tick) begin
      tmr_r <= tmr_r - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;

  assign rd_mux = sel_data ? {16'h0000, (drq ? buf_rdata : 16'h0000)} :
                  sel_errfeat ? {24'h000000, err_r} :
                  sel_seccnt ? {24'h000000, seccnt_r} :
                  sel_secnum ? {24'h000000, secnum_r} :
                  sel_cyllo ? {24'h000000, cyllo_r} :
                  sel_cylhi ? {24'h000000, cylhi_r} :
                  sel_devhead ? {24'h000000, devhead_r} :
                  sel_statcmd ? {24'h000000, status} :
                  sel_config ? {31'h00000000, smart_en_r} :
                  sel_info ? {6'h00, tmr_en_r, standby_r, buf_csum, cap_word} :
                  32'h00000000;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_r <= 32'h00000000;
    end else if (setup) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata_o = prdata_r;
  assign intrq_o = intrq_r;
  assign nv_save_req_o = state_r == ata_cmd_pkg::ST_SAVE_WAIT;
  assign standby_o = standby_r;

endmodule : ata_cmd_engine

// ===== verilog/ata_cmd_pkg.sv
package ata_cmd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned STBY_UNIT_MS = 5000;
  localparam int unsigned STBY_UNIT_CYCLES_DFLT = STBY_UNIT_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_ERRFEAT = 8'h04;
  localparam logic [7:0] OFF_SECCNT = 8'h08;
  localparam logic [7:0] OFF_SECNUM = 8'h0c;
  localparam logic [7:0] OFF_CYLLO = 8'h10;
  localparam logic [7:0] OFF_CYLHI = 8'h14;
  localparam logic [7:0] OFF_DEVHEAD = 8'h18;
  localparam logic [7:0] OFF_STATCMD = 8'h1c;
  localparam logic [7:0] OFF_CONFIG = 8'h20;
  localparam logic [7:0] OFF_INFO = 8'h24;

  // ----------------------------------------------------------------
  // Command and subcommand codes, signatures
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SMART = 8'hb0;
  localparam logic [7:0] CMD_STBY_A = 8'h96;
  localparam logic [7:0] CMD_STBY_B = 8'he2;
  localparam logic [7:0] CMD_STBYI_A = 8'h94;
  localparam logic [7:0] CMD_STBYI_B = 8'he0;
  localparam logic [7:0] CMD_WR_BUF = 8'he8;
  localparam logic [7:0] CMD_RD_BUF = 8'he4;
  localparam logic [7:0] FEAT_STATUS = 8'hda;
  localparam logic [7:0] FEAT_SAVE = 8'hd3;
  localparam logic [7:0] SIG_LO = 8'h4f;
  localparam logic [7:0] SIG_HI = 8'hc2;
  localparam logic [7:0] BAD_LO = 8'hf4;
  localparam logic [7:0] BAD_HI = 8'h2c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CAP_PRE_SAVE = 0;
  localparam int unsigned CAP_AUTOSAVE = 1;
  localparam logic [7:0] ERR_ABRT = 8'h04;
  localparam int unsigned INFO_CSUM_LSB = 16;
  localparam logic [7:0] DEVHEAD_RST = 8'ha0;
  localparam logic CONFIG_SMART_RST = 1'b1;
  localparam int unsigned BUF_WORDS = 256;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SAVE_WAIT, ST_WR_PREP, ST_WR_DATA, ST_RD_PREP, ST_RD_DATA, ST_DONE
  } state_t;

  typedef enum logic [1:0] {
    OP_STATUS, OP_SAVE, OP_STANDBY, OP_AUTO
  } op_t;

endpackage : ata_cmd_pkg

// ===== verilog/sector_buf.sv
module sector_buf #(
  parameter int unsigned WORDS = ata_cmd_pkg::BUF_WORDS
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic last_o,
  output logic [7:0] csum_o
);

  localparam int unsigned IW = $clog2(WORDS);
  localparam logic [IW-1:0] LAST_IDX = IW'(WORDS - 1);

  logic [15:0] mem_r [WORDS];
  logic [IW-1:0] idx_r;
  logic [7:0] sum_r;
  logic [7:0] sum_nxt;

  // ----------------------------------------------------------------
  // Running byte sum; the last byte of the sector is left out
  // ----------------------------------------------------------------
  assign sum_nxt = sum_r + wdata_i[7:0] + (last_o ? 8'h00 : wdata_i[15:8]);
  assign csum_o = 8'h00 - sum_r;
  assign last_o = idx_r == LAST_IDX;
  assign rdata_o = mem_r[idx_r];

  always_ff @(posedge core_clk_i) begin
    if (wr_i) begin
      mem_r[idx_r] <= wdata_i;
    end
  end

  // One shared index for writing and reading back the same sector
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idx_r <= '0;
      sum_r <= 8'h00;
    end else if (clr_i) begin
      idx_r <= '0;
      sum_r <= 8'h00;
    end else if (wr_i) begin
      idx_r <= idx_r + IW'(1);
      sum_r <= sum_nxt;
    end else if (rd_i) begin
      idx_r <= idx_r + IW'(1);
    end
  end

endmodule : sector_buf

// ===== tb/ata_cmd_engine_props.sv
module ata_cmd_engine_props #(
  parameter bit PRE_SAVE_CAP = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic intrq_o,
  input wire logic nv_save_req_o,
  input wire logic nv_save_ack_i,
  input wire logic thresh_exceeded_i,
  input wire logic standby_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Shadow of host writes
  // ----------------------------------------------------------------
  logic [7:0] feat_r, lo_r, hi_r, cnt_r;
  logic en_r, smart_op_r, stby_op_r, wb_r;
  wire wr_w = psel_i & penable_i & pwrite_i;
  wire cmd_w = wr_w & (paddr_i == ata_cmd_pkg::OFF_STATCMD);
  wire good_w = en_r & (lo_r == 8'h4f) & (hi_r == 8'hc2) & ((feat_r == 8'hda) | (feat_r == 8'hd3));
  wire smart_w = cmd_w & (pwdata_i[7:0] == 8'hb0);
  wire stby_w = cmd_w & (pwdata_i[7:0] inside {8'h96, 8'he2, 8'h94, 8'he0});
  wire done_w = nv_save_req_o & nv_save_ack_i;
  wire last_w = wr_w & (paddr_i == ata_cmd_pkg::OFF_DATA) & wb_r & (cnt_r == 8'hff);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {feat_r, lo_r, hi_r, cnt_r, smart_op_r, stby_op_r, wb_r} <= '0;
      en_r <= 1'b1;
    end else begin
      if (wr_w && paddr_i == ata_cmd_pkg::OFF_ERRFEAT) feat_r <= pwdata_i[7:0];
      if (wr_w && paddr_i == ata_cmd_pkg::OFF_CYLLO) lo_r <= pwdata_i[7:0];
      if (wr_w && paddr_i == ata_cmd_pkg::OFF_CYLHI) hi_r <= pwdata_i[7:0];
      if (wr_w && paddr_i == ata_cmd_pkg::OFF_CONFIG) en_r <= pwdata_i[0];
      if (done_w) smart_op_r <= 1'b0;
      if (done_w) stby_op_r <= 1'b0;
      if (smart_w) smart_op_r <= good_w;
      if (stby_w) stby_op_r <= 1'b1;
      if (wr_w && paddr_i == ata_cmd_pkg::OFF_DATA && wb_r) cnt_r <= cnt_r + 8'h01;
      if (cmd_w) cnt_r <= 8'h00;
      if (cmd_w) wb_r <= (pwdata_i[7:0] == 8'he8);
    end
  end
  AST_SMART_SAVE_START: assert property (smart_w && good_w |-> ##[1:2] nv_save_req_o)
    else $error("smart subcommand gave no save request");
  AST_SMART_ABORT: assert property (smart_w && !good_w |=> (!nv_save_req_o)[*2] ##[0:1] intrq_o)
    else $error("bad smart subcommand not aborted");
  AST_SAVE_REQ_DROP: assert property (done_w |=> !nv_save_req_o)
    else $error("save request held after acknowledge");
  AST_SMART_DONE_INTRQ: assert property (done_w && smart_op_r |-> ##[2:3] intrq_o)
    else $error("no interrupt after smart save");
  AST_STBY_SAVE_START: assert property (stby_w && PRE_SAVE_CAP |-> ##[1:2] nv_save_req_o)
    else $error("standby command gave no save request");
  AST_STBY_ENTER: assert property (done_w && stby_op_r |-> ##[1:2] standby_o)
    else $error("standby not entered after save");
  AST_STBY_AFTER_SAVE: assert property ($rose(standby_o) && PRE_SAVE_CAP |-> $past(done_w) || $past(done_w, 2))
    else $error("standby entered without a save");
  AST_WRBUF_INTRQ: assert property (last_w |-> ##[2:3] intrq_o)
    else $error("no interrupt after last buffer word");
endmodule : ata_cmd_engine_props

bind ata_cmd_engine ata_cmd_engine_props #(.PRE_SAVE_CAP(PRE_SAVE_CAP)) u_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .intrq_o(intrq_o), .nv_save_req_o(nv_save_req_o),
  .nv_save_ack_i(nv_save_ack_i), .thresh_exceeded_i(thresh_exceeded_i), .standby_o(standby_o));

// ===== tb/nv_store_model.sv
module nv_store_model (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic [3:0] lat_i,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  // Acknowledge one cycle after lat_i waiting cycles
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 4'h0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (!req_i || ack_o) begin
        cnt_r <= 4'h0;
      end else if (cnt_r == lat_i) begin
        ack_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule : nv_store_model

// ===== tb/ata_smart_standby_buffer_cmds_tb.sv
module ata_smart_standby_buffer_cmds_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, nrst_i, psel_i, penable_i, pwrite_i, perr;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic pready_o, pslverr_o, intrq_o, nv_save_req_o, nv_save_ack_i, thresh_exceeded_i, standby_o;
  logic [3:0] lat;
  int bad_count, cmp_count;
  logic [7:0] sf [6] = '{8'hda, 8'hda, 8'hd3, 8'h55, 8'hda, 8'hda};
  logic [7:0] sl [6] = '{8'h4f, 8'h4f, 8'h4f, 8'h4f, 8'h4e, 8'h4f};
  logic [7:0] sc [4] = '{8'h00, 8'h02, 8'h05, 8'h00};
  logic [7:0] cm [4] = '{8'h96, 8'he2, 8'h94, 8'he0};
  logic tm [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  ata_cmd_engine #(.STBY_UNIT_CYCLES(20)) u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .intrq_o(intrq_o), .nv_save_req_o(nv_save_req_o), .nv_save_ack_i(nv_save_ack_i),
    .thresh_exceeded_i(thresh_exceeded_i), .standby_o(standby_o));
  nv_store_model u_nv (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(nv_save_req_o),
    .lat_i(lat), .ack_o(nv_save_ack_i));
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : apb
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rchk
  task automatic cmd(input logic [7:0] c);
    logic [31:0] q;
    wr(ata_cmd_pkg::OFF_DEVHEAD, 32'ha0);
    apb(1'b0, ata_cmd_pkg::OFF_STATCMD, 32'h0, q);
    chk(q & 32'hc8, 32'h40);
    wr(ata_cmd_pkg::OFF_STATCMD, {24'h0, c});
  endtask : cmd
  task automatic wait_hi(input bit s);
    int n;
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while ((s ? standby_o : intrq_o) !== 1'b1 && n < 500);
    chk({31'h0, n < 500}, 32'h1);
    @(posedge core_clk_i);
  endtask : wait_hi
  task automatic stat(input logic [31:0] e);
    rchk(ata_cmd_pkg::OFF_STATCMD, e);
    @(negedge core_clk_i);
    chk({31'h0, intrq_o}, 32'h0);
    @(posedge core_clk_i);
  endtask : stat
  task automatic wait_drq();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      apb(1'b0, ata_cmd_pkg::OFF_STATCMD, 32'h0, q);
      n++;
    end while (q[3] !== 1'b1 && n < 20);
    chk(q & 32'h88, 32'h08);
  endtask : wait_drq
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    rchk(ata_cmd_pkg::OFF_DEVHEAD, 32'ha0);
    rchk(ata_cmd_pkg::OFF_CONFIG, 32'h1);
    apb(1'b0, ata_cmd_pkg::OFF_INFO, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'h1);
    apb(1'b0, 8'h40, 32'h0, q);
    chk({perr, q[30:0]}, 32'h8000_0000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_smart();
    for (int i = 0; i < 6; i++) begin
      thresh_exceeded_i <= (i == 1);
      lat <= 4'(i * 3);
      wr(ata_cmd_pkg::OFF_CONFIG, {31'h0, i != 5});
      wr(ata_cmd_pkg::OFF_ERRFEAT, {24'h0, sf[i]});
      wr(ata_cmd_pkg::OFF_CYLLO, {24'h0, sl[i]});
      wr(ata_cmd_pkg::OFF_CYLHI, 32'hc2);
      cmd(ata_cmd_pkg::CMD_SMART);
      wait_hi(1'b0);
      stat(i > 2 ? 32'h41 : 32'h40);
      rchk(ata_cmd_pkg::OFF_ERRFEAT, i > 2 ? 32'h04 : 32'h00);
      rchk(ata_cmd_pkg::OFF_CYLLO, i == 1 ? 32'hf4 : {24'h0, sl[i]});
      rchk(ata_cmd_pkg::OFF_CYLHI, i == 1 ? 32'h2c : 32'hc2);
    end
    wr(ata_cmd_pkg::OFF_CONFIG, 32'h1);
    $display("smart test done");
  endtask : t_smart
  task automatic t_buf();
    logic [31:0] q;
    logic [7:0] s;
    logic [15:0] w;
    s = 8'h00;
    cmd(ata_cmd_pkg::CMD_WR_BUF);
    wait_drq();
    for (int i = 0; i < 256; i++) begin
      w = {8'(i) ^ 8'h3c, 8'(i)};
      s = s + w[7:0] + (i < 255 ? w[15:8] : 8'h00);
      wr(ata_cmd_pkg::OFF_DATA, {16'h0, w});
    end
    wait_hi(1'b0);
    stat(32'h40);
    apb(1'b0, ata_cmd_pkg::OFF_INFO, 32'h0, q);
    chk({24'h0, q[23:16]}, {24'h0, 8'h00 - s});
    cmd(ata_cmd_pkg::CMD_RD_BUF);
    wait_drq();
    for (int i = 0; i < 256; i++) begin
      apb(1'b0, ata_cmd_pkg::OFF_DATA, 32'h0, q);
      chk(q, {16'h0, 8'(i) ^ 8'h3c, 8'(i)});
    end
    stat(32'h40);
    $display("buffer test done");
  endtask : t_buf
  task automatic t_stby();
    logic [31:0] q;
    lat <= 4'h2;
    for (int i = 0; i < 4; i++) begin
      wr(ata_cmd_pkg::OFF_SECCNT, {24'h0, sc[i]});
      cmd(cm[i]);
      wait_hi(1'b0);
      wait_hi(1'b1);
      stat(32'h40);
      apb(1'b0, ata_cmd_pkg::OFF_INFO, 32'h0, q);
      chk({30'h0, q[25:24]}, {30'h0, tm[i], 1'b1});
    end
    cmd(ata_cmd_pkg::CMD_SMART);
    wait_hi(1'b0);
    stat(32'h40);
    wait_hi(1'b1);
    @(negedge core_clk_i);
    chk({31'h0, intrq_o}, 32'h0);
    @(posedge core_clk_i);
    wr(ata_cmd_pkg::OFF_SECCNT, 32'h0);
    cmd(ata_cmd_pkg::CMD_STBY_A);
    wait_hi(1'b0);
    stat(32'h40);
    apb(1'b0, ata_cmd_pkg::OFF_INFO, 32'h0, q);
    chk({31'h0, q[25]}, 32'h0);
    $display("standby test done");
  endtask : t_stby
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, thresh_exceeded_i, lat} = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_smart();
    t_buf();
    t_stby();
    complete_run();
  end
endmodule : ata_smart_standby_buffer_cmds_tb
